// >>> hdl/cws_pkg.sv
package cws_pkg;

  // ----------------------------------------------------------------
  // Register indices (word address; byte address is four times this)
  // ----------------------------------------------------------------
  localparam logic [7:0] IDX_BRIDGE1 = 8'h10;
  localparam logic [7:0] IDX_BRIDGE_SUM = 8'h14;
  localparam logic [7:0] IDX_TEMPERATURE = 8'h15;
  localparam logic [7:0] IDX_TDC_RESOLUTION = 8'h18;
  localparam logic [7:0] IDX_SUPPLY_VOLTAGE = 8'h19;
  localparam logic [7:0] IDX_KEY_FALL = 8'h1a;
  localparam logic [7:0] IDX_KEY_RISE = 8'h1b;
  localparam logic [7:0] IDX_KEY_PRESSED = 8'h1c;
  localparam logic [7:0] IDX_GPIO_STATUS = 8'h1d;
  localparam logic [7:0] IDX_TIMER_SNAPSHOT = 8'h1e;
  localparam logic [7:0] IDX_SPAN_RATIO = 8'h1f;
  localparam logic [7:0] IDX_CONTROL = 8'h40;
  localparam logic [7:0] IDX_SEQ_STATE = 8'h41;
  localparam logic [7:0] IDX_WAKE_STATUS = 8'hf6;

  // ----------------------------------------------------------------
  // Control register fields and reset value
  // ----------------------------------------------------------------
  localparam int CTL_AUTO_CFG = 0;
  localparam int CTL_PWR_PRG = 1;
  localparam int CTL_USR_PRG = 2;
  localparam int CTL_SLEEP = 3;
  localparam int CTL_SPAN_MODE = 4;
  localparam int CTL_WDT_EN = 5;
  localparam logic [5:0] CTL_RESET = 6'h20;

  // ----------------------------------------------------------------
  // Status word fields
  // ----------------------------------------------------------------
  localparam int ST_CAP_STATE_LSB = 20;
  localparam int ST_POR = 19;
  localparam int ST_BUTTON = 18;
  localparam int ST_WDT = 17;
  localparam int ST_END_MEAS = 16;
  localparam int ST_SLEEP = 15;
  localparam int ST_LOW_SUPPLY = 14;
  localparam int ST_TDC_ERR = 13;
  localparam int ST_CAP_ERR = 11;
  localparam int ST_SG_ERR = 10;
  localparam int ST_TIMEOUT = 9;
  localparam int ST_EXT_INT = 8;
  localparam int ST_RISE_LSB = 4;
  localparam int ST_FALL_LSB = 0;
  localparam logic [23:0] STATUS_RESET = 24'h000000;

  // ----------------------------------------------------------------
  // Program addresses and counts
  // ----------------------------------------------------------------
  localparam logic [15:0] ROM_ENTRY_ADDR = 16'hf000;
  localparam logic [15:0] USER_CODE_ADDR = 16'h0030;
  localparam int WDT_START_LIMIT = 4;

  typedef enum logic [2:0] {
    SEQ_IDLE, SEQ_ROM, SEQ_CFG, SEQ_PWR, SEQ_MEAS, SEQ_USR, SEQ_RUN, SEQ_STOP
  } cws_seq_t;

endpackage

// >>> hdl/cws_sequencer.sv
`timescale 1ns/1ns
// Functional notes
// RULE_01 Wake on reset, measurement, sleep counter; reset first
// RULE_02 Every activation enters ROM code first
// RULE_03 Reset wake copies configuration when enabled
// RULE_04 Power flag: run user code or stop
// RULE_05 Non-reset wake starts measurement or counter
// RULE_06 User flag decides jump to user code
// RULE_07 Stop fully resets ALU, keeps RAM
// RULE_08 Power-on resets chip but not RAM
// RULE_09 Four unclear starts trigger watchdog reset
// RULE_10 Watchdog cause is status bit 17
// RULE_11 Status bits 23..20 hold capacitive states
// RULE_12 Bits 19..16 hold jump cause
// RULE_13 Bits 15..12 sleep, low supply, converter, reserved
// RULE_14 Bits 11..8 port, gauge, timeout, interrupt
// RULE_15 Bits 7..0 capacitive rising, falling edges
// RULE_16 Word 24 holds converter resolution
// RULE_17 Word 25 holds supply measurement
// RULE_18 Words 26..28 hold key status
// RULE_19 Word 29 holds GPIO status
// RULE_20 Word 30 snapshots timer at completion
// RULE_21 Word 31 span value or ratio
// RULE_22 Bridge, temperature stored two's complement
// RULE_23 Watchdog counts measurement starts
// RULE_24 Pin edges clear the watchdog
// RULE_25 Cause flags updated before user jump
module cws_sequencer (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic button_reset,
  input wire logic measure_done,
  input wire logic conv_count_done,
  input wire logic clear_watchdog,
  input wire logic chip_select_reset_pin,
  input wire logic core_stop,
  input wire logic cfg_copy_done,
  input wire logic [3:0] cap_port_state,
  input wire logic [3:0] cap_port_rise,
  input wire logic [3:0] cap_port_fall,
  input wire logic low_supply_flag,
  input wire logic tdc_error,
  input wire logic cap_port_error,
  input wire logic gauge_port_error,
  input wire logic tdc_timeout,
  input wire logic ext_interrupt,
  input wire logic [23:0] cal_value,
  input wire logic [23:0] supply_voltage_value,
  input wire logic [23:0] key_fall,
  input wire logic [23:0] key_rise,
  input wire logic [23:0] key_pressed,
  input wire logic [23:0] gpio_status,
  input wire logic [23:0] rtc_value,
  input wire logic [23:0] span_value,
  input wire logic [23:0] span_ratio,
  input wire logic [23:0] bridge1_in,
  input wire logic [23:0] bridge_sum_in,
  input wire logic [23:0] temperature_in,
  output logic pc_load,
  output logic [15:0] pc_value,
  output logic cfg_copy_req,
  output logic meas_start,
  output logic conv_restart,
  output logic alu_reset,
  output logic cpu_running
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  cws_pkg::cws_seq_t state;
  cws_pkg::cws_seq_t next_state;
  logic [5:0] ctrl;
  logic [23:0] status;
  logic pend_por;
  logic pend_button;
  logic pend_wdt;
  logic pend_event;
  logic is_reset;
  logic ack;
  logic wdt_trip;
  logic [23:0] ram [0:10];

  // ----------------------------------------------------------------
  // Wake decisions
  // ----------------------------------------------------------------
  wire sleep_mode = ctrl[cws_pkg::CTL_SLEEP];
  wire reset_pend = pend_por | pend_button | pend_wdt;
  wire wake_event = sleep_mode ? conv_count_done : measure_done; // RULE_01
  wire take_wake = (state == cws_pkg::SEQ_IDLE) & (reset_pend | pend_event);
  wire take_reset = take_wake & reset_pend; // RULE_01
  // A trip in the jump cycle must not launch user code
  wire run_user = ((state == cws_pkg::SEQ_PWR) & ctrl[cws_pkg::CTL_PWR_PRG]
    | (state == cws_pkg::SEQ_USR) & ctrl[cws_pkg::CTL_USR_PRG]) & ~wdt_trip;
  wire start_meas = (state == cws_pkg::SEQ_MEAS) & ~sleep_mode;
  wire bus_req = avs_read | avs_write;
  wire bus_write = avs_write & ack;

  function automatic logic [3:0] ram_slot(input logic [7:0] idx);
    ram_slot = 4'(idx - cws_pkg::IDX_TDC_RESOLUTION);
  endfunction

  // ----------------------------------------------------------------
  // Sequencer state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      cws_pkg::SEQ_IDLE: begin
        if (reset_pend | pend_event) begin
          next_state = cws_pkg::SEQ_ROM; // RULE_02
        end
      end
      cws_pkg::SEQ_ROM: begin
        if (!is_reset) begin
          next_state = cws_pkg::SEQ_MEAS;
        end else if (ctrl[cws_pkg::CTL_AUTO_CFG]) begin
          next_state = cws_pkg::SEQ_CFG; // RULE_03
        end else begin
          next_state = cws_pkg::SEQ_PWR;
        end
      end
      cws_pkg::SEQ_CFG: begin
        if (cfg_copy_done) begin
          next_state = cws_pkg::SEQ_PWR;
        end
      end
      cws_pkg::SEQ_PWR: begin
        next_state = run_user ? cws_pkg::SEQ_RUN : cws_pkg::SEQ_STOP; // RULE_04
      end
      cws_pkg::SEQ_MEAS: begin
        next_state = cws_pkg::SEQ_USR;
      end
      cws_pkg::SEQ_USR: begin
        next_state = run_user ? cws_pkg::SEQ_RUN : cws_pkg::SEQ_STOP; // RULE_06
      end
      cws_pkg::SEQ_RUN: begin
        if (core_stop) begin
          next_state = cws_pkg::SEQ_STOP;
        end
      end
      cws_pkg::SEQ_STOP: begin
        next_state = cws_pkg::SEQ_IDLE;
      end
    endcase
    // A tripped watchdog aborts any run through a full ALU reset
    if (wdt_trip && state != cws_pkg::SEQ_IDLE) begin
      next_state = cws_pkg::SEQ_STOP;
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      state <= cws_pkg::SEQ_IDLE;
      is_reset <= 1'b0;
    end else begin
      state <= next_state;
      if (take_wake) begin
        is_reset <= reset_pend;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pending wake sources; a new request wins over its own clear
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pend_por <= 1'b1; // RULE_08
      pend_button <= 1'b0;
      pend_wdt <= 1'b0;
      pend_event <= 1'b0;
    end else begin
      pend_por <= pend_por & ~take_reset;
      pend_button <= button_reset | pend_button & ~take_reset;
      pend_wdt <= wdt_trip | pend_wdt & ~take_reset; // RULE_09
      pend_event <= wake_event | pend_event & ~(take_wake & ~reset_pend);
    end
  end

  // ----------------------------------------------------------------
  // Outputs to core and measurement unit
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pc_load <= 1'b0;
      pc_value <= cws_pkg::ROM_ENTRY_ADDR;
      meas_start <= 1'b0;
      conv_restart <= 1'b0;
      alu_reset <= 1'b1;
      cpu_running <= 1'b0;
    end else begin
      pc_load <= take_wake | run_user;
      if (take_wake) begin
        pc_value <= cws_pkg::ROM_ENTRY_ADDR; // RULE_02
      end else if (run_user) begin
        pc_value <= cws_pkg::USER_CODE_ADDR; // RULE_04 RULE_06
      end
      meas_start <= start_meas; // RULE_05
      conv_restart <= (state == cws_pkg::SEQ_MEAS) & sleep_mode; // RULE_05
      alu_reset <= (state == cws_pkg::SEQ_STOP); // RULE_07
      cpu_running <= (next_state == cws_pkg::SEQ_RUN);
    end
  end

  assign cfg_copy_req = (state == cws_pkg::SEQ_CFG); // RULE_03

  cws_watchdog #(
    .LIMIT(cws_pkg::WDT_START_LIMIT)
  ) u_watchdog (
    .mclk(mclk),
    .rstn(rstn),
    .enable(ctrl[cws_pkg::CTL_WDT_EN]),
    .count_start(start_meas),
    .clear_opcode(clear_watchdog),
    .chip_select_reset_pin(chip_select_reset_pin),
    .trip(wdt_trip)
  );

  // ----------------------------------------------------------------
  // Status word
  // ----------------------------------------------------------------
  // Causes are written on the wake edge, long before any user jump
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      status <= cws_pkg::STATUS_RESET;
    end else begin
      if (take_wake) begin
        status[cws_pkg::ST_POR] <= reset_pend; // RULE_12 RULE_25
        status[cws_pkg::ST_BUTTON] <= take_reset & pend_button; // RULE_12
        status[cws_pkg::ST_WDT] <= take_reset & pend_wdt; // RULE_10
        status[cws_pkg::ST_END_MEAS] <= ~reset_pend & ~sleep_mode; // RULE_12
        status[cws_pkg::ST_SLEEP] <= ~reset_pend & sleep_mode; // RULE_13
      end
      if (measure_done) begin
        status[cws_pkg::ST_CAP_STATE_LSB +: 4] <= cap_port_state; // RULE_11
        status[cws_pkg::ST_LOW_SUPPLY] <= low_supply_flag; // RULE_13
        status[cws_pkg::ST_TDC_ERR] <= tdc_error; // RULE_13
        status[cws_pkg::ST_CAP_ERR] <= cap_port_error; // RULE_14
        status[cws_pkg::ST_SG_ERR] <= gauge_port_error; // RULE_14
        status[cws_pkg::ST_TIMEOUT] <= tdc_timeout; // RULE_14
        status[cws_pkg::ST_RISE_LSB +: 4] <= cap_port_rise; // RULE_15
        status[cws_pkg::ST_FALL_LSB +: 4] <= cap_port_fall; // RULE_15
      end
      status[12] <= 1'b0; // RULE_13
      if (take_wake) begin
        status[cws_pkg::ST_EXT_INT] <= ext_interrupt; // RULE_14
      end
    end
  end

  // ----------------------------------------------------------------
  // Result words: RAM is never reset, so contents survive any reset
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (measure_done) begin
      ram[0] <= cal_value; // RULE_16
      ram[1] <= supply_voltage_value; // RULE_17
      ram[2] <= key_fall; // RULE_18
      ram[3] <= key_rise; // RULE_18
      ram[4] <= key_pressed; // RULE_18
      ram[5] <= gpio_status; // RULE_19
      ram[6] <= rtc_value; // RULE_20
      ram[7] <= ctrl[cws_pkg::CTL_SPAN_MODE] ? span_ratio : span_value; // RULE_21
      ram[8] <= bridge1_in; // RULE_22
      ram[9] <= bridge_sum_in; // RULE_22
      ram[10] <= temperature_in; // RULE_22
    end
  end

  // ----------------------------------------------------------------
  // Avalon slave: one wait state on every access
  // ----------------------------------------------------------------
  wire hit_result = avs_address >= cws_pkg::IDX_TDC_RESOLUTION
    && avs_address <= cws_pkg::IDX_SPAN_RATIO;
  wire [23:0] result_word = hit_result ? ram[ram_slot(avs_address)] : 24'h000000;
  logic [23:0] read_mux;

  always_comb begin
    read_mux = result_word;
    unique case (avs_address)
      cws_pkg::IDX_BRIDGE1: read_mux = ram[8];
      cws_pkg::IDX_BRIDGE_SUM: read_mux = ram[9];
      cws_pkg::IDX_TEMPERATURE: read_mux = ram[10];
      cws_pkg::IDX_CONTROL: read_mux = {18'h00000, ctrl};
      cws_pkg::IDX_SEQ_STATE: read_mux = {21'h000000, state};
      cws_pkg::IDX_WAKE_STATUS: read_mux = status;
      default: read_mux = result_word;
    endcase
  end

  assign avs_waitrequest = bus_req & ~ack;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      ack <= 1'b0;
      avs_readdata <= 32'h00000000;
      ctrl <= cws_pkg::CTL_RESET;
    end else begin
      ack <= bus_req & ~ack;
      if (avs_read && !ack) begin
        avs_readdata <= {8'h00, read_mux};
      end
      if (bus_write && avs_address == cws_pkg::IDX_CONTROL && avs_byteenable[0]) begin
        ctrl <= avs_writedata[5:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_reset_wins_prio: assert property (@(posedge mclk) disable iff (!rstn) // RULE_01
    take_wake && reset_pend |=> is_reset)
    else $error("Event wake taken over pending reset");
  a_rom_entry_first: assert property (@(posedge mclk) disable iff (!rstn) // RULE_02
    take_wake |=> pc_load && pc_value == cws_pkg::ROM_ENTRY_ADDR)
    else $error("Activation did not enter ROM code");
  a_cfg_copy_gate: assert property (@(posedge mclk) disable iff (!rstn) // RULE_03
    $rose(cfg_copy_req) |-> is_reset && ctrl[cws_pkg::CTL_AUTO_CFG])
    else $error("Configuration copy without reset or flag");
  a_user_jump_addr: assert property (@(posedge mclk) disable iff (!rstn) // RULE_06
    $rose(cpu_running) |-> pc_load && pc_value == cws_pkg::USER_CODE_ADDR)
    else $error("User run started off the user entry");
  a_meas_or_conv: assert property (@(posedge mclk) disable iff (!rstn) // RULE_05
    state == cws_pkg::SEQ_MEAS && !wdt_trip |=> meas_start != conv_restart
      && conv_restart == sleep_mode)
    else $error("Wrong measurement or counter start");
  a_stop_alu_reset: assert property (@(posedge mclk) disable iff (!rstn) // RULE_07
    state == cws_pkg::SEQ_RUN && core_stop |=> ##1 alu_reset)
    else $error("Stop did not reset the ALU");
  a_wdt_cause_flag: assert property (@(posedge mclk) disable iff (!rstn) // RULE_10
    take_reset && pend_wdt |=> status[cws_pkg::ST_WDT]
      && !status[cws_pkg::ST_END_MEAS])
    else $error("Watchdog cause not flagged");
  a_cause_before_jump: assert property (@(posedge mclk) disable iff (!rstn) // RULE_25
    $rose(cpu_running) |-> status[cws_pkg::ST_POR] == is_reset
      && (is_reset || status[cws_pkg::ST_END_MEAS] != status[cws_pkg::ST_SLEEP]))
    else $error("Cause flags not ready before user jump");
  a_span_select: assert property (@(posedge mclk) disable iff (!rstn) // RULE_21
    measure_done && ctrl[cws_pkg::CTL_SPAN_MODE] |=> ram[7] == $past(span_ratio))
    else $error("Span ratio not stored in span mode");
  a_timer_snapshot: assert property (@(posedge mclk) disable iff (!rstn) // RULE_20
    measure_done |=> ram[6] == $past(rtc_value) && ram[0] == $past(cal_value))
    else $error("Timer snapshot not loaded");
  a_bus_one_wait: assert property (@(posedge mclk) disable iff (!rstn)
    bus_req && !ack |=> !avs_waitrequest || !bus_req)
    else $error("Bus answer later than one wait state");

endmodule

// >>> hdl/cws_watchdog.sv
`timescale 1ns/1ns
module cws_watchdog #(
  parameter int LIMIT = cws_pkg::WDT_START_LIMIT
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic enable,
  input wire logic count_start,
  input wire logic clear_opcode,
  input wire logic chip_select_reset_pin,
  output logic trip
);

  logic [2:0] starts;
  logic pin_last;
  wire pin_edge = chip_select_reset_pin ^ pin_last;
  wire do_clear = clear_opcode | pin_edge | ~enable;
  wire at_limit = (starts == 3'(LIMIT - 1)) & count_start;

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      pin_last <= 1'b1;
    end else begin
      pin_last <= chip_select_reset_pin;
    end
  end

  // Clear beats count: a cleared run never trips
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      starts <= 3'h0;
      trip <= 1'b0;
    end else begin
      trip <= at_limit & ~do_clear; // RULE_09
      if (do_clear) begin
        starts <= 3'h0; // RULE_24
      end else if (at_limit) begin
        starts <= 3'h0;
      end else if (count_start) begin
        starts <= starts + 3'h1; // RULE_23
      end
    end
  end

  a_wdt_trip_count: assert property (@(posedge mclk) disable iff (!rstn) // RULE_09
    trip |-> $past(starts) == 3'(LIMIT - 1))
    else $error("Watchdog tripped before the start limit");
  a_wdt_pin_clear: assert property (@(posedge mclk) disable iff (!rstn) // RULE_24
    pin_edge |=> starts == 3'h0 && !trip)
    else $error("Pin edge did not clear the watchdog");

endmodule

// >>> tb/cws_far_end.sv
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Core stand-in: copies config, clears watchdog, stops
// ----------------------------------------------------------------
module cws_far_end #(
  parameter int COPY_CYC = 3,
  parameter int RUN_CYC = 6
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic cfg_copy_req,
  input wire logic cpu_running,
  input wire logic clr_en,
  output logic cfg_copy_done,
  output logic clear_watchdog,
  output logic core_stop
);
  int cnt;
  always @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      cnt <= 0;
      cfg_copy_done <= 1'b0;
      clear_watchdog <= 1'b0;
      core_stop <= 1'b0;
    end else begin
      cfg_copy_done <= 1'b0;
      clear_watchdog <= 1'b0;
      core_stop <= 1'b0;
      // Request stays up one cycle past done, so skip that cycle
      if (cfg_copy_req && !cfg_copy_done) begin
        cnt <= cnt + 1;
        if (cnt == COPY_CYC) begin
          cfg_copy_done <= 1'b1;
          cnt <= 0;
        end
      end else if (cpu_running && !core_stop) begin
        cnt <= cnt + 1;
        clear_watchdog <= clr_en && (cnt == 1);
        if (cnt == RUN_CYC) begin
          core_stop <= 1'b1;
          cnt <= 0;
        end
      end else begin
        cnt <= 0;
      end
    end
  end
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ns
module testbench;
  logic mclk, rstn, avs_read, avs_write, avs_waitrequest, alu_q, clr_en;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  logic [3:0] avs_byteenable, cap_port_state, cap_port_rise, cap_port_fall;
  logic button_reset, measure_done, conv_count_done, clear_watchdog;
  logic chip_select_reset_pin, core_stop, cfg_copy_done, low_supply_flag;
  logic tdc_error, cap_port_error, gauge_port_error, tdc_timeout, ext_interrupt;
  logic pc_load, cfg_copy_req, meas_start, conv_restart, alu_reset, cpu_running;
  logic [23:0] cal_value, supply_voltage_value, key_fall, key_rise, key_pressed;
  logic [23:0] gpio_status, rtc_value, span_value, span_ratio, bridge1_in;
  logic [23:0] bridge_sum_in, temperature_in;
  logic [15:0] pc_value;
  logic [15:0] pcs[$];
  int failures, checks_done, n_meas, n_rst, n_cfg, n_stop;

  cws_sequencer dut (.*);
  // Slow copy answer to exercise the config wait
  cws_far_end #(.COPY_CYC(5)) far (.*);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Sampled mid-cycle so counts never race the waiting scenario
  always @(negedge mclk) begin
    alu_q <= alu_reset;
    if (pc_load === 1'b1) pcs.push_back(pc_value);
    n_meas += (meas_start === 1'b1);
    n_rst += (conv_restart === 1'b1);
    n_cfg += (cfg_copy_req === 1'b1);
    if (rstn && alu_reset === 1'b1 && alu_q === 1'b0) n_stop++;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic bus(logic we, logic [7:0] a, logic [31:0] d);
    int i;
    avs_read <= !we;
    avs_write <= we;
    avs_address <= a;
    avs_writedata <= d;
    for (i = 0; i < 50; i++) begin
      @(posedge mclk);
      if (avs_waitrequest === 1'b0) break;
    end
    rdat = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (i == 50) begin
      failures++;
      end_sim();
    end
    @(posedge mclk);
  endtask

  task automatic rd(logic [7:0] a, logic [31:0] e, string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, rdat, e);
  endtask

  task automatic prep(logic [31:0] ctl);
    bus(1'b1, cws_pkg::IDX_CONTROL, ctl);
    pcs.delete();
    n_meas = 0;
    n_rst = 0;
    n_cfg = 0;
    n_stop = 0;
  endtask

  // Bit 0 end of measurement, 1 button, 2 sleep counter
  task automatic pulse(logic [2:0] m);
    {conv_count_done, button_reset, measure_done} <= m;
    @(posedge mclk);
    {conv_count_done, button_reset, measure_done} <= 3'h0;
  endtask

  task automatic wait_stop(int n);
    for (int i = 0; i < 400 && n_stop < n; i++) @(posedge mclk);
    if (n_stop < n) begin
      failures++;
      $display("[ERR] stop count exp %0d seen %0d", n, n_stop);
      end_sim();
    end
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_por;
    wait_stop(1);
    chk("rom entry", pcs[0], 32'hf000);
    chk("pc loads", pcs.size(), 1);
    rd(cws_pkg::IDX_CONTROL, 32'h20, "control");
    rd(cws_pkg::IDX_WAKE_STATUS, 32'h080100, "por status");
    bus(1'b1, cws_pkg::IDX_WAKE_STATUS, 32'hffffff);
    rd(cws_pkg::IDX_WAKE_STATUS, 32'h080100, "status ro");
    rd(8'h80, 32'h0, "unmapped");
    $display("test por done");
  endtask

  task automatic t_cfg;
    prep(32'h27);
    pulse(3'b010);
    wait_stop(1);
    chk("copy req", n_cfg != 0, 1);
    chk("user jump", pcs[pcs.size()-1], 32'h0030);
    rd(cws_pkg::IDX_WAKE_STATUS, 32'h0c0100, "button status");
    $display("test cfg done");
  endtask

  task automatic t_meas(logic span);
    logic [7:0] ix [11] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d, 8'h1e,
                            8'h1f, 8'h10, 8'h14, 8'h15};
    logic [23:0] ex [11] = '{24'h0003e8, 24'h000020, 24'h000011, 24'h000022,
                             24'h000033, 24'h000044, 24'h123456, 24'h000055,
                             24'h800001, 24'hfffffe, 24'h000077};
    prep(32'h24 | (32'(span) << cws_pkg::CTL_SPAN_MODE));
    if (span) ex[7] = 24'h000066;
    pulse(3'b001);
    wait_stop(1);
    chk("meas start", n_meas, 1);
    chk("entry", pcs[0], 32'hf000);
    chk("user jump", pcs[1], 32'h0030);
    rd(cws_pkg::IDX_WAKE_STATUS, 32'ha16553, "meas status");
    for (int i = 0; i < 11; i++) begin
      rd(ix[i], {8'h0, ex[i]}, "result");
    end
    $display("test meas done");
  endtask

  task automatic t_sleep;
    prep(32'h2c);
    pulse(3'b100);
    wait_stop(1);
    chk("restart", n_rst, 1);
    chk("no meas", n_meas, 0);
    chk("user jump", pcs[1], 32'h0030);
    rd(cws_pkg::IDX_WAKE_STATUS, 32'ha0e553, "sleep status");
    $display("test sleep done");
  endtask

  task automatic t_prio;
    prep(32'h24);
    pulse(3'b011);
    wait_stop(1);
    chk("reset first", n_meas, 0);
    chk("no jump", pcs.size(), 1);
    wait_stop(2);
    chk("event later", n_meas, 1);
    chk("event jump", pcs[2], 32'h0030);
    $display("test prio done");
  endtask

  task automatic t_wdt;
    clr_en <= 1'b0;
    prep(32'h26);
    for (int k = 1; k <= 7; k++) begin
      if (k == 4) chip_select_reset_pin <= ~chip_select_reset_pin;
      pulse(3'b001);
      wait_stop(k == 7 ? 8 : k);
    end
    chk("trip", n_meas, 7);
    bus(1'b0, cws_pkg::IDX_WAKE_STATUS, 32'h0);
    chk("wdt flag", rdat[cws_pkg::ST_WDT], 1);
    chk("por flag", rdat[cws_pkg::ST_POR], 1);
    chk("wdt jump", pcs[pcs.size()-1], 32'h0030);
    clr_en <= 1'b1;
    $display("test wdt done");
  endtask

  task automatic t_rst;
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    rd(cws_pkg::IDX_TDC_RESOLUTION, 32'h0003e8, "ram kept");
    rd(cws_pkg::IDX_CONTROL, 32'h20, "control reset");
    $display("test rst done");
  endtask

  initial begin
    {rstn, avs_read, avs_write, button_reset, measure_done, conv_count_done} = 6'h0;
    // Chip select idles high; converter error set to exercise its flag
    {chip_select_reset_pin, tdc_error, cap_port_error, tdc_timeout} = 4'hc;
    {low_supply_flag, gauge_port_error, ext_interrupt, clr_en} = 4'hf;
    avs_address = 8'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    {cap_port_state, cap_port_rise, cap_port_fall} = 12'ha53;
    {cal_value, supply_voltage_value, key_fall} = {24'h3e8, 24'h20, 24'h11};
    {key_rise, key_pressed, gpio_status} = {24'h22, 24'h33, 24'h44};
    {rtc_value, span_value, span_ratio} = {24'h123456, 24'h55, 24'h66};
    {bridge1_in, bridge_sum_in, temperature_in} = {24'h800001, 24'hfffffe, 24'h77};
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    t_por();
    t_cfg();
    t_meas(1'b0);
    t_meas(1'b1);
    t_sleep();
    t_prio();
    t_wdt();
    t_rst();
    end_sim();
  end
endmodule
